// *** verilog/uch_channel_regs.v ***
`timescale 1ns/10ps
`default_nettype none
`include "uch_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Modem control bit 4 set enters loopback; clearing it leaves loopback.
// - In loopback the transmit shift output feeds the receive shift input.
// - In loopback the transmit pin is held high at mark.
// - In loopback request-to-send and terminal-ready pins stay deasserted.
// - In loopback the four modem input pins are ignored.
// - All other channel functions keep working unchanged in loopback.
// - Own register set per channel; chip and channel select pick responder.
// - Line control bit 7 clear: address 0 reads rx and writes tx holding.
// - Divisor bank: addresses 0,1,2 are divisor low, high, alt function.
// - Divisor both zero: addresses 0,1 read revision and identity codes.
// - Normal bank: 1 is interrupt enable; 2 reads status, writes FIFO ctrl.
// - 3,4 line and modem control; 5,6 read status, writes reserved.
// - Feature bit 6 clear: address 7 is read/write scratch pad.
// - Feature bit 6 set: address 7 reads FIFO level, writes mode select.
// - Key 0xBF: address 0 trigger/level, 1 feature, 2 enhanced function.
// - Key 0xBF: addresses 4 to 7 are the four flow characters.
// - Enhanced-only bits read zero and are inert without enhanced enable.
module uch_channel_regs #(
    parameter       CHANNEL_SEL   = 1'b0,
    parameter [7:0] REVISION_CODE = `UCH_DEF_REVISION,
    parameter [7:0] IDENTITY_CODE = `UCH_DEF_IDENTITY
) (
    input  wire       sys_clk,
    input  wire       rst,
    // Host bus pins
    input  wire       chipSelectN,
    input  wire       channelSelect,
    input  wire       readStrobeN,
    input  wire       writeStrobeN,
    input  wire [2:0] address,
    input  wire [7:0] dataIn,
    output reg  [7:0] dataOut,
    output wire       dataOutEn,
    // Serial and modem pins
    input  wire       rxPin,
    input  wire       clearToSendN,
    input  wire       dataSetReadyN,
    input  wire       carrier_detect_n,
    input  wire       ring_indicate_n,
    output wire       txPin,
    output wire       requestToSendN,
    output wire       terminalReadyN,
    // Channel datapath side
    input  wire       txSerial,
    output wire       rxSerial,
    input  wire [7:0] rxHoldingData,
    input  wire [7:0] interruptStatusIn,
    input  wire [7:0] lineStatusIn,
    input  wire [7:0] fifoLevelIn,
    output reg        rxHoldingRead,
    output reg        interruptStatusRead,
    output reg        lineStatusRead,
    output reg        txHoldingWrite,
    output reg        fifoControlWrite,
    output reg        triggerLevelWrite,
    output reg        modeSelectWrite,
    output reg  [7:0] writeData,
    output wire [7:0] fifoControlData,
    output wire [7:0] baudDivisorLow,
    output wire [7:0] baudDivisorHigh,
    output wire [7:0] altFunction,
    output wire [7:0] interruptEnable,
    output wire [7:0] featureControl,
    output wire [7:0] enhancedFunction,
    output wire [7:0] lineControl,
    output wire [7:0] modemControl,
    output wire [7:0] flowCharOne,
    output wire [7:0] flowCharTwo,
    output wire [7:0] flowCharThree,
    output wire [7:0] flowCharFour,
    output wire       loopbackActive
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    wire [19:0] pinsSync;
    wire        csSyncN;
    wire        chanSync;
    wire        rdSyncN;
    wire        wrSyncN;
    wire [2:0]  addrSync;
    wire [7:0]  dataSync;
    wire        rxSync;
    wire [3:0]  modemPinsSyncN;

    uch_sync2 #(
        .WIDTH   (20),
        .RST_VAL (20'hFFFFF)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn ({chipSelectN, channelSelect, readStrobeN, writeStrobeN,
                   address, dataIn, rxPin, carrier_detect_n,
                   ring_indicate_n, dataSetReadyN, clearToSendN}),
        .syncOut (pinsSync)
    );

    assign csSyncN        = pinsSync[19];
    assign chanSync       = pinsSync[18];
    assign rdSyncN        = pinsSync[17];
    assign wrSyncN        = pinsSync[16];
    assign addrSync       = pinsSync[15:13];
    assign dataSync       = pinsSync[12:5];
    assign rxSync         = pinsSync[4];
    assign modemPinsSyncN = pinsSync[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [7:0] divLowReg;
    reg  [7:0] divHighReg;
    reg  [7:0] altFuncReg;
    reg  [7:0] intEnableReg;
    reg  [7:0] fifoCtrlReg;
    reg  [7:0] lineCtrlReg;
    reg  [7:0] modemCtrlReg;
    reg  [7:0] scratchReg;
    reg  [7:0] featureReg;
    reg  [7:0] enhFuncReg;
    reg  [7:0] flowChar [0:3];
    reg  [3:0] modemDelta;
    reg  [3:0] modemPrev;
    reg        readActive;
    reg        prevRdN;
    reg        prevWrN;
    reg        prevSel;
    reg  [2:0] prevAddr;
    reg  [7:0] prevData;
    reg  [7:0] next_readData;
    wire [3:0] modemLevels;
    wire       selected;
    wire       readTake;
    wire       writeTake;
    wire       enhEnable;
    wire       divBank;
    wire       enhBank;
    wire       divZero;
    wire [7:0] ierMask;
    wire [7:0] isrMask;
    wire [7:0] fcrMask;
    wire [7:0] mcrMask;
    wire [7:0] modemStatus;

    // Chip select and channel select choose this register set
    assign selected  = ~csSyncN & (chanSync == CHANNEL_SEL);
    assign readTake  = selected & prevRdN & ~rdSyncN;
    assign writeTake = prevSel & ~prevWrN & wrSyncN;
    assign dataOutEn = readActive & ~rdSyncN;

    assign enhEnable = enhFuncReg[`UCH_EFR_ENH_BIT];
    assign enhBank   = (lineCtrlReg == `UCH_LCR_ENH_KEY);
    assign divBank   = lineCtrlReg[`UCH_LCR_DIV_BIT] & ~enhBank;
    assign divZero   = (divLowReg == `UCH_DIV_ZERO) &
                       (divHighReg == `UCH_DIV_ZERO);

    // Gated bit groups
    assign ierMask = enhEnable ? 8'hFF : ~`UCH_IER_ENH_MASK;
    assign isrMask = enhEnable ? 8'hFF : ~`UCH_ISR_ENH_MASK;
    assign fcrMask = enhEnable ? 8'hFF : ~`UCH_FCR_ENH_MASK;
    assign mcrMask = enhEnable ? 8'hFF : ~`UCH_MCR_ENH_MASK;

    assign baudDivisorLow   = divLowReg;
    assign baudDivisorHigh  = divHighReg;
    assign altFunction      = altFuncReg;
    assign interruptEnable  = intEnableReg & ierMask;
    assign fifoControlData  = fifoCtrlReg & fcrMask;
    assign featureControl   = featureReg;
    assign enhancedFunction = enhFuncReg;
    assign lineControl      = lineCtrlReg;
    assign modemControl     = modemCtrlReg & mcrMask;
    assign flowCharOne      = flowChar[0];
    assign flowCharTwo      = flowChar[1];
    assign flowCharThree    = flowChar[2];
    assign flowCharFour     = flowChar[3];
    assign loopbackActive   = modemCtrlReg[`UCH_MCR_LOOP_BIT];

    assign modemStatus = {modemLevels, modemDelta};

    ////////////////////////////////////////////////////////////////////////////
    // Loopback routing of serial and modem pins
    uch_loop_route u_loop (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .loopback    (loopbackActive),
        .txSerial    (txSerial),
        .rxPinSync   (rxSync),
        .modemBits   (modemCtrlReg[3:0]),
        .modemPinsN  (modemPinsSyncN),
        .txPin       (txPin),
        .rtsPinN     (requestToSendN),
        .dtrPinN     (terminalReadyN),
        .rxSerial    (rxSerial),
        .modemLevels (modemLevels)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection
    always @* begin
        next_readData = `UCH_IDLE_READ;
        if (enhBank) begin
            if (addrSync == `UCH_ADDR_HOLDING) begin
                next_readData = fifoLevelIn;
            end else if (addrSync == `UCH_ADDR_INT_ENABLE) begin
                next_readData = featureReg;
            end else if (addrSync == `UCH_ADDR_INT_STATUS) begin
                next_readData = enhFuncReg;
            end else if (addrSync == `UCH_ADDR_LINE_CTRL) begin
                next_readData = lineCtrlReg;
            end else begin
                next_readData = flowChar[addrSync[1:0]];
            end
        end else if (divBank &&
                     addrSync <= `UCH_ADDR_INT_STATUS) begin
            if (addrSync == `UCH_ADDR_HOLDING) begin
                next_readData = divZero ? REVISION_CODE
                                        : divLowReg;
            end else if (addrSync == `UCH_ADDR_INT_ENABLE) begin
                next_readData = divZero ? IDENTITY_CODE
                                        : divHighReg;
            end else begin
                next_readData = altFuncReg;
            end
        end else if (addrSync == `UCH_ADDR_HOLDING) begin
            next_readData = rxHoldingData;
        end else if (addrSync == `UCH_ADDR_INT_ENABLE) begin
            next_readData = intEnableReg & ierMask;
        end else if (addrSync == `UCH_ADDR_INT_STATUS) begin
            next_readData = interruptStatusIn & isrMask;
        end else if (addrSync == `UCH_ADDR_LINE_CTRL) begin
            next_readData = lineCtrlReg;
        end else if (addrSync == `UCH_ADDR_MODEM_CTRL) begin
            next_readData = modemCtrlReg & mcrMask;
        end else if (addrSync == `UCH_ADDR_LINE_STAT) begin
            next_readData = lineStatusIn;
        end else if (addrSync == `UCH_ADDR_MODEM_STAT) begin
            next_readData = modemStatus;
        end else if (featureReg[`UCH_FEATURE_CONTROL_SWAP_BIT]) begin
            next_readData = fifoLevelIn;
        end else begin
            next_readData = scratchReg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe tracking, read capture and read side effects
    always @(posedge sys_clk) begin
        if (rst) begin
            prevRdN             <= 1'b1;
            prevWrN             <= 1'b1;
            prevSel             <= 1'b0;
            prevAddr            <= 3'h0;
            prevData            <= 8'h00;
            readActive          <= 1'b0;
            dataOut             <= `UCH_IDLE_READ;
            rxHoldingRead       <= 1'b0;
            interruptStatusRead <= 1'b0;
            lineStatusRead      <= 1'b0;
        end else begin
            prevRdN  <= rdSyncN;
            prevWrN  <= wrSyncN;
            prevSel  <= selected;
            prevAddr <= addrSync;
            prevData <= dataSync;
            rxHoldingRead       <= 1'b0;
            interruptStatusRead <= 1'b0;
            lineStatusRead      <= 1'b0;
            if (rdSyncN) begin
                readActive <= 1'b0;
            end else if (readTake) begin
                readActive <= 1'b1;
                dataOut    <= next_readData;
            end
            if (readTake && !enhBank && !divBank) begin
                rxHoldingRead <=
                    (addrSync == `UCH_ADDR_HOLDING);
                interruptStatusRead <=
                    (addrSync == `UCH_ADDR_INT_STATUS);
                lineStatusRead <=
                    (addrSync == `UCH_ADDR_LINE_STAT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem status deltas, cleared by a read; a new change wins
    always @(posedge sys_clk) begin
        if (rst) begin
            modemPrev  <= 4'h0;
            modemDelta <= 4'h0;
        end else begin
            modemPrev <= modemLevels;
            if (readTake && !enhBank &&
                addrSync == `UCH_ADDR_MODEM_STAT) begin
                modemDelta <= modemLevels ^ modemPrev;
            end else begin
                modemDelta <= modemDelta | (modemLevels ^ modemPrev);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, taken at the end of the write strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            divLowReg         <= `UCH_RST_REG;
            divHighReg        <= `UCH_RST_REG;
            altFuncReg        <= `UCH_RST_REG;
            intEnableReg      <= `UCH_RST_REG;
            fifoCtrlReg       <= `UCH_RST_REG;
            lineCtrlReg       <= `UCH_RST_REG;
            modemCtrlReg      <= `UCH_RST_REG;
            scratchReg        <= `UCH_RST_SCRATCH;
            featureReg        <= `UCH_RST_REG;
            enhFuncReg        <= `UCH_RST_REG;
            flowChar[0]       <= `UCH_RST_REG;
            flowChar[1]       <= `UCH_RST_REG;
            flowChar[2]       <= `UCH_RST_REG;
            flowChar[3]       <= `UCH_RST_REG;
            writeData         <= 8'h00;
            txHoldingWrite    <= 1'b0;
            fifoControlWrite  <= 1'b0;
            triggerLevelWrite <= 1'b0;
            modeSelectWrite   <= 1'b0;
        end else begin
            txHoldingWrite    <= 1'b0;
            fifoControlWrite  <= 1'b0;
            triggerLevelWrite <= 1'b0;
            modeSelectWrite   <= 1'b0;
            if (writeTake) begin
                writeData <= prevData;
                if (prevAddr == `UCH_ADDR_LINE_CTRL) begin
                    lineCtrlReg <= prevData;
                end else if (enhBank) begin
                    if (prevAddr == `UCH_ADDR_HOLDING) begin
                        triggerLevelWrite <= 1'b1;
                    end else if (prevAddr == `UCH_ADDR_INT_ENABLE) begin
                        featureReg <= prevData;
                    end else if (prevAddr == `UCH_ADDR_INT_STATUS) begin
                        enhFuncReg <= prevData;
                    end else begin
                        flowChar[prevAddr[1:0]] <= prevData;
                    end
                end else if (divBank &&
                             prevAddr <= `UCH_ADDR_INT_STATUS) begin
                    if (prevAddr == `UCH_ADDR_HOLDING) begin
                        divLowReg <= prevData;
                    end else if (prevAddr == `UCH_ADDR_INT_ENABLE) begin
                        divHighReg <= prevData;
                    end else begin
                        altFuncReg <= prevData;
                    end
                end else if (prevAddr == `UCH_ADDR_HOLDING) begin
                    txHoldingWrite <= 1'b1;
                end else if (prevAddr == `UCH_ADDR_INT_ENABLE) begin
                    intEnableReg <= (prevData & ierMask) |
                                    (intEnableReg & ~ierMask);
                end else if (prevAddr == `UCH_ADDR_INT_STATUS) begin
                    fifoControlWrite <= 1'b1;
                    fifoCtrlReg <= (prevData & fcrMask) |
                                   (fifoCtrlReg & ~fcrMask);
                end else if (prevAddr == `UCH_ADDR_MODEM_CTRL) begin
                    modemCtrlReg <= (prevData & mcrMask) |
                                    (modemCtrlReg & ~mcrMask);
                end else if (prevAddr == `UCH_ADDR_SCRATCH) begin
                    if (featureReg[`UCH_FEATURE_CONTROL_SWAP_BIT]) begin
                        modeSelectWrite <= 1'b1;
                    end else begin
                        scratchReg <= prevData;
                    end
                end
                // Status addresses 5 and 6 drop the write
            end
        end
    end

    // Loopback only reroutes pins; framing, FIFO and interrupt paths are
    // untouched

endmodule // uch_channel_regs

`default_nettype wire

// *** inc/uch_defines.vh ***
`ifndef UCH_DEFINES_VH
`define UCH_DEFINES_VH

// Register addresses on the three address pins
`define UCH_ADDR_HOLDING    3'h0
`define UCH_ADDR_INT_ENABLE 3'h1
`define UCH_ADDR_INT_STATUS 3'h2
`define UCH_ADDR_LINE_CTRL  3'h3
`define UCH_ADDR_MODEM_CTRL 3'h4
`define UCH_ADDR_LINE_STAT  3'h5
`define UCH_ADDR_MODEM_STAT 3'h6
`define UCH_ADDR_SCRATCH    3'h7

// Bank selection
`define UCH_LCR_ENH_KEY     8'hBF
`define UCH_LCR_DIV_BIT     7
`define UCH_MCR_LOOP_BIT    4
`define UCH_FEATURE_CONTROL_SWAP_BIT   6
`define UCH_EFR_ENH_BIT     4
`define UCH_DIV_ZERO        8'h00

// Bits that only live while the enhanced enable is set
`define UCH_IER_ENH_MASK    8'hF0
`define UCH_ISR_ENH_MASK    8'h30
`define UCH_FCR_ENH_MASK    8'h30
`define UCH_MCR_ENH_MASK    8'hE0

// Modem control output bits
`define UCH_MCR_DTR_BIT     0
`define UCH_MCR_RTS_BIT     1
`define UCH_MCR_OP1_BIT     2
`define UCH_MCR_OP2_BIT     3

// Reset values
`define UCH_RST_REG         8'h00
`define UCH_RST_SCRATCH     8'hFF
`define UCH_IDLE_READ       8'h00

// Default identity values, arbitrary
`define UCH_DEF_REVISION    8'h01
`define UCH_DEF_IDENTITY    8'hA5

`endif

// *** verilog/uch_sync2.v ***
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for pins from outside the clock domain
module uch_sync2 #(
    parameter WIDTH    = 20,
    parameter RST_VAL  = 20'hFFFFF
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stageOne;

    always @(posedge sys_clk) begin
        if (rst) begin
            stageOne <= RST_VAL;
            syncOut  <= RST_VAL;
        end else begin
            stageOne <= asyncIn;
            syncOut  <= stageOne;
        end
    end

endmodule // uch_sync2

`default_nettype wire

// *** verilog/uch_loop_route.v ***
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Pin routing between normal operation and internal loopback
module uch_loop_route (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       loopback,
    input  wire       txSerial,
    input  wire       rxPinSync,
    input  wire [3:0] modemBits,
    input  wire [3:0] modemPinsN,
    output reg        txPin,
    output reg        rtsPinN,
    output reg        dtrPinN,
    output reg        rxSerial,
    output reg  [3:0] modemLevels
);

    // modemBits: {op2, op1, rts, dtr}; modemPinsN: {cd, ri, dsr, cts}
    always @(posedge sys_clk) begin
        if (rst) begin
            txPin       <= 1'b1;
            rtsPinN     <= 1'b1;
            dtrPinN     <= 1'b1;
            rxSerial    <= 1'b1;
            modemLevels <= 4'h0;
        end else if (loopback) begin
            txPin       <= 1'b1;
            rtsPinN     <= 1'b1;
            dtrPinN     <= 1'b1;
            rxSerial    <= txSerial;
            // Outputs fed back instead of pins
            modemLevels <= {modemBits[3], modemBits[2],
                            modemBits[0], modemBits[1]};
        end else begin
            txPin       <= txSerial;
            rtsPinN     <= ~modemBits[1];
            dtrPinN     <= ~modemBits[0];
            rxSerial    <= rxPinSync;
            modemLevels <= ~modemPinsN;
        end
    end

endmodule // uch_loop_route

`default_nettype wire

// *** verification/uch_regs_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module uch_regs_monitor (
    input wire logic       sys_clk, rst, loopbackActive, txPin, txSerial,
    input wire logic       requestToSendN, terminalReadyN, rxSerial,
    input wire logic       txHoldingWrite, triggerLevelWrite,
    input wire logic       modeSelectWrite, fifoControlWrite,
    input wire logic [7:0] modemControl, interruptEnable, fifoControlData,
    input wire logic [7:0] enhancedFunction, lineControl, featureControl
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_loop_bit: assert property (
        loopbackActive == modemControl[4]) else $error("loop flag");
    a_loop_rx_path: assert property (
        loopbackActive && $past(loopbackActive) |-> rxSerial == $past(txSerial)
    ) else $error("loop rx path");
    a_loop_tx_mark: assert property (
        loopbackActive && $past(loopbackActive) |-> txPin) else $error("tx");
    a_loop_modem_off: assert property (
        loopbackActive && $past(loopbackActive) |->
        requestToSendN && terminalReadyN) else $error("modem outputs");
    a_normal_modem_out: assert property (
        !loopbackActive && !$past(loopbackActive) && $stable(modemControl)
        |-> requestToSendN == !modemControl[1] &&
        terminalReadyN == !modemControl[0]) else $error("modem follow");
    a_tx_write_bank: assert property (
        txHoldingWrite |-> !lineControl[7]) else $error("tx write bank");
    a_trig_write_key: assert property (
        triggerLevelWrite |-> lineControl == 8'hBF) else $error("trigger");
    a_mode_write_swap: assert property (
        modeSelectWrite |-> featureControl[6] && !lineControl[7]
    ) else $error("mode select");
    a_fifo_write_pulse: assert property (
        fifoControlWrite |-> !lineControl[7] ##1 !fifoControlWrite
    ) else $error("fifo control");
    a_enh_bits_zero: assert property (
        !enhancedFunction[4] |-> interruptEnable[7:4] == 4'h0 &&
        modemControl[7:5] == 3'h0 && fifoControlData[5:4] == 2'h0
    ) else $error("enhanced bits");
endmodule // uch_regs_monitor
bind uch_channel_regs uch_regs_monitor uch_regs_monitor_i (.*);
`default_nettype wire

// *** verification/uch_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module uch_host_model (
    input wire logic       sys_clk,
    input wire logic [7:0] dataOut,
    input wire logic       dataOutEn,
    output logic           chipSelectN, channelSelect, readStrobeN,
    output logic           writeStrobeN,
    output logic [2:0]     address,
    output logic [7:0]     dataIn
);
    logic chan = 1'b0;
    initial begin
        {chipSelectN, readStrobeN, writeStrobeN, channelSelect} = 4'hE;
        {address, dataIn} = 11'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        step(1);
        {address, dataIn, channelSelect} = {a, d, chan};
        {chipSelectN, writeStrobeN} = 2'h0;
        step(4);
        writeStrobeN = 1'b1;
        step(5);
        chipSelectN = 1'b1;
        dataIn = ~d; // Released bus shows no stale value
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        step(1);
        {address, channelSelect} = {a, chan};
        {chipSelectN, readStrobeN} = 2'h0;
        step(5);
        d = dataOutEn ? dataOut : ~dataOut; // Undriven bus never matches
        readStrobeN = 1'b1;
        step(5);
        chipSelectN = 1'b1;
    endtask
endmodule // uch_host_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, rst = 1'b1, txSerial = 1'b1;
    logic rxPin = 1'b1;
    logic clearToSendN = 1'b1, dataSetReadyN = 1'b1;
    logic carrier_detect_n = 1'b1, ring_indicate_n = 1'b1;
    logic [7:0] rxHoldingData = 8'h5A, interruptStatusIn = 8'hC1;
    logic [7:0] lineStatusIn = 8'h60, fifoLevelIn = 8'h21;
    logic chipSelectN, channelSelect, readStrobeN, writeStrobeN, dataOutEn;
    logic txPin, requestToSendN, terminalReadyN, rxSerial, loopbackActive;
    logic rxHoldingRead, interruptStatusRead, lineStatusRead, txHoldingWrite;
    logic fifoControlWrite, triggerLevelWrite, modeSelectWrite;
    logic [2:0] address;
    logic [7:0] dataIn, dataOut, writeData, fifoControlData, altFunction;
    logic [7:0] baudDivisorLow, baudDivisorHigh, interruptEnable, rdv;
    logic [7:0] featureControl, enhancedFunction, lineControl, modemControl;
    logic [7:0] flowCharOne, flowCharTwo, flowCharThree, flowCharFour;
    int err_total = 0;
    int samples_checked = 0;
    int rxReads = 0;
    int statusReads = 0;
    logic [7:0] lastTx = 8'h00;
    uch_channel_regs uch_channel_regs_i (.*);
    uch_host_model uch_host_model_i (.*);
    always #4 sys_clk = ~sys_clk;
    // Side-effect pulses seen by the datapath
    always @(posedge sys_clk) begin
        if (rxHoldingRead) rxReads <= rxReads + 1;
        if (interruptStatusRead || lineStatusRead)
            statusReads <= statusReads + 1;
        if (txHoldingWrite) lastTx <= writeData;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        uch_host_model_i.wr(a, d);
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        uch_host_model_i.rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        rchk(3'h0, 8'h5A);
        chk(8'(rxReads), 8'h01);
        rchk(3'h7, 8'hFF);
        w(3'h7, 8'h3C);
        w(3'h0, 8'h96);
        chk(lastTx, 8'h96);
        w(3'h2, 8'h01);
        rchk(3'h2, 8'hC1);
        w(3'h5, 8'h55);
        rchk(3'h5, 8'h60);
        chk(8'(statusReads), 8'h02);
        rchk(3'h7, 8'h3C);
        w(3'h3, 8'h80);
        rchk(3'h0, 8'h01);
        rchk(3'h1, 8'hA5);
        w(3'h0, 8'h12);
        w(3'h2, 8'h07);
        rchk(3'h0, 8'h12);
        rchk(3'h1, 8'h00);
        rchk(3'h2, 8'h07);
        chk(baudDivisorLow, 8'h12);
        chk(altFunction, 8'h07);
        chk(8'(rxReads + statusReads), 8'h03);
        w(3'h3, 8'hBF);
        w(3'h1, 8'h40);
        w(3'h2, 8'h10);
        w(3'h0, 8'h44);
        rchk(3'h0, 8'h21);
        rchk(3'h1, 8'h40);
        for (int i = 4; i < 8; i++) w(3'(i), 8'(i * 17));
        for (int i = 4; i < 8; i++) rchk(3'(i), 8'(i * 17));
        chk(flowCharOne, 8'h44);
        chk(flowCharFour, 8'h77);
        chk(8'(rxReads), 8'h01);
        rchk(3'h3, 8'hBF);
        w(3'h3, 8'h03);
        w(3'h1, 8'hFF);
        rchk(3'h1, 8'hFF);
        rchk(3'h7, 8'h21);
        w(3'h7, 8'h33);
        w(3'h3, 8'hBF);
        w(3'h2, 8'h00);
        w(3'h3, 8'h03);
        rchk(3'h1, 8'h0F);
        uch_host_model_i.chan = 1'b1;
        w(3'h3, 8'h80);
        uch_host_model_i.chan = 1'b0;
        rchk(3'h3, 8'h03);
        w(3'h4, 8'h13);
        {clearToSendN, dataSetReadyN, carrier_detect_n, ring_indicate_n} = 4'h0;
        txSerial = 1'b0;
        uch_host_model_i.rd(3'h6, rdv);
        chk(rdv & 8'hF0, 8'h30);
        chk({4'h0, txPin, requestToSendN, terminalReadyN, rxSerial},
            8'h0E);
        w(3'h4, 8'h03);
        uch_host_model_i.rd(3'h6, rdv);
        chk(rdv & 8'hF0, 8'hF0);
        chk({5'h0, txPin, requestToSendN, terminalReadyN}, 8'h00);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
